/* hdl/pcc_filt.sv */
// Two-flop synchroniser with a stability filter for one field input
`timescale 1ns/1ps
module pcc_filt #(
   parameter int FILT_CYC = 16,
   parameter logic RST_VAL = 1'b1
) (
   input wire logic mclk, // System clock
   input wire logic sys_rst, // Async reset, high
   input wire logic pin, // Raw field level
   output logic level // Filtered level
);
   localparam int CW = $clog2(FILT_CYC + 1);

   logic s1_reg;
   logic s2_reg;
   logic lvl_reg;
   logic lvl_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   // Level accepted only after it held for the whole window
   always_comb begin
      lvl_next = lvl_reg;
      cnt_next = '0;
      if (s2_reg != lvl_reg) begin
         if (cnt_reg == CW'(FILT_CYC - 1)) begin
            lvl_next = s2_reg;
         end else begin
            cnt_next = cnt_reg + CW'(1);
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         lvl_reg <= RST_VAL;
         cnt_reg <= '0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         lvl_reg <= lvl_next;
         cnt_reg <= cnt_next;
      end
   end

   assign level = lvl_reg;
endmodule

/* hdl/pcc_top.sv */
// Presettable up/down BCD event counter with timed or latched outputs
`timescale 1ns/1ps
module pcc_top #(
   parameter int DUAL = 1,
   parameter int TICK_CYC = pcc_pkg::TICK_CYC,
   parameter int DIR_CYC = pcc_pkg::DIR_CYC,
   parameter int RRST_CYC = pcc_pkg::RRST_CYC
) (
   input wire logic mclk, // 100 MHz clock
   input wire logic sys_rst, // Async reset, high
   input wire logic [3:0] reg_addr, // Register index
   input wire logic [15:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [15:0] reg_rdata, // Read data, next cycle
   input wire logic cnt_in, // Count pulses, falling edge
   input wire logic count_direction_in, // High up, low down
   input wire logic remote_rst_n, // Remote reset, low
   input wire logic prog_lock_n, // Program lock, low
   input wire logic front_rst_btn, // Front reset button
   input wire logic front_rst_en, // Rear enable switch
   input wire logic [3:0] mode_sw, // Mode switches, down is 1
   input wire logic [pcc_pkg::NV_W-1:0] nv_image_in, // Stored image
   input wire logic nv_valid_in, // Image holds data
   output logic [pcc_pkg::NV_W-1:0] nv_image_out, // Live image
   output logic nv_store, // Image changed, pulse
   output logic [1:0] ss_out, // Solid-state outputs
   output logic [1:0] relay_out // Relay outputs
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int FIN = (DUAL != 0) ? 1 : 0;

   // ****************************************
   // Input conditioning
   // ****************************************
   logic cnt_lvl;
   logic dir_lvl;
   logic rrst_lvl;
   logic lock_lvl;
   logic fbtn_lvl;
   logic fen_lvl;
   logic [3:0] msw1_reg;
   logic [3:0] mode_reg;

   // filter shorter than legal low pulse
   pcc_filt #(.FILT_CYC(pcc_pkg::IN_FILT_CYC), .RST_VAL(1'b1)) u_cnt (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(cnt_in),
      .level(cnt_lvl)
   );
   // direction held 150 us before use
   pcc_filt #(.FILT_CYC(DIR_CYC), .RST_VAL(1'b1)) u_dir (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(count_direction_in),
      .level(dir_lvl)
   );
   pcc_filt #(.FILT_CYC(RRST_CYC), .RST_VAL(1'b1)) u_rrst (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(remote_rst_n),
      .level(rrst_lvl)
   );
   pcc_filt #(.FILT_CYC(pcc_pkg::IN_FILT_CYC), .RST_VAL(1'b1)) u_lock (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(prog_lock_n),
      .level(lock_lvl)
   );
   pcc_filt #(.FILT_CYC(pcc_pkg::IN_FILT_CYC), .RST_VAL(1'b0)) u_fbtn (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(front_rst_btn),
      .level(fbtn_lvl)
   );
   pcc_filt #(.FILT_CYC(pcc_pkg::IN_FILT_CYC), .RST_VAL(1'b0)) u_fen (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(front_rst_en),
      .level(fen_lvl)
   );

   // ****************************************
   // State
   // ****************************************
   pcc_pkg::pcc_state_e state_reg;
   pcc_pkg::pcc_state_e state_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [15:0] pre_reg [2];
   logic [15:0] pre_next [2];
   logic [15:0] dur_reg [2];
   logic [15:0] dur_next [2];
   logic [15:0] tim_reg [2];
   logic [15:0] tim_next [2];
   logic [1:0] out_reg;
   logic [1:0] out_next;
   logic [1:0] pin_reg;
   logic [1:0] pin_next;
   logic [2:0] ctrl_reg;
   logic [2:0] ctrl_next;
   logic [TW-1:0] tick_reg;
   logic [TW-1:0] tick_next;
   logic cprev_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic store_reg;
   logic store_next;

   // Combinational helpers
   logic tick_ev;
   logic cnt_ev;
   logic act_zero;
   logic man_rst;
   logic [2:0] m;
   logic [15:0] start_val;
   logic [15:0] step;
   logic [15:0] targ [2];
   logic [1:0] hit;
   logic [1:0] timed;
   logic [1:0] end_ev;
   logic split;
   logic [15:0] status;
   logic [15:0] wval;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pre_next = pre_reg;
      dur_next = dur_reg;
      tim_next = tim_reg;
      out_next = out_reg;
      ctrl_next = ctrl_reg;
      end_ev = 2'b00;
      tick_ev = (tick_reg == TW'(TICK_CYC - 1));
      tick_next = tick_ev ? '0 : tick_reg + TW'(1);
      act_zero = ~mode_reg[pcc_pkg::MODE_ACT_BIT];
      m = mode_reg[2:0];
      // split modes exist only when dual
      split = (DUAL != 0) &&
              (m == pcc_pkg::MODE_SPLIT_L || m == pcc_pkg::MODE_SPLIT_T);
      // dual preset-start starts at preset 2
      start_val = act_zero ? pcc_pkg::COUNT_RST :
                  ((DUAL != 0) ? pre_reg[1] : pre_reg[0]);
      // front button gated by rear switch
      man_rst = ~rrst_lvl | (fbtn_lvl & fen_lvl);
      cnt_ev = cprev_reg & ~cnt_lvl;
      step = dir_lvl ? pcc_pkg::bcd_inc(cnt_reg) : pcc_pkg::bcd_dec(cnt_reg);
      // output 1 at preset 1 when dual
      targ[0] = (act_zero || DUAL != 0) ? pre_reg[0] : pcc_pkg::COUNT_RST;
      targ[1] = act_zero ? pre_reg[1] : pcc_pkg::COUNT_RST;
      for (int i = 0; i < 2; i++) begin
         hit[i] = cnt_ev && (step == targ[i]) && (i == 0 || DUAL != 0);
         timed[i] = (m == pcc_pkg::MODE_TIMED) ||
                    (m == pcc_pkg::MODE_AUTO_HIT) ||
                    (m == pcc_pkg::MODE_AUTO_END) ||
                    (i == 1 && DUAL != 0 && m == pcc_pkg::MODE_SPLIT_T);
      end

      wval = (reg_wdata == 16'h0000) ? pcc_pkg::DUR_MIN : reg_wdata;
      if (state_reg == pcc_pkg::PCC_ST_RESTORE) begin
         if (nv_valid_in) begin
            cnt_next = nv_image_in[pcc_pkg::NV_CNT_LSB +: 16];
            for (int i = 0; i < 2; i++) begin
               pre_next[i] = nv_image_in[pcc_pkg::NV_PRE_LSB + 16*i +: 16];
               dur_next[i] = nv_image_in[pcc_pkg::NV_DUR_LSB + 16*i +: 16];
            end
         end
         state_next = pcc_pkg::PCC_ST_RUN;
      end else begin
         // timed output in 10 ms ticks
         for (int i = 0; i < 2; i++) begin
            if (tick_ev && out_reg[i] && timed[i] && tim_reg[i] != 16'h0000) begin
               tim_next[i] = pcc_pkg::bcd_dec(tim_reg[i]);
               if (tim_reg[i] == pcc_pkg::DUR_MIN) begin
                  out_next[i] = 1'b0;
                  end_ev[i] = 1'b1;
               end
            end
            if (hit[i]) begin
               out_next[i] = 1'b1;
               if (timed[i]) begin
                  tim_next[i] = dur_reg[i];
               end
            end
         end
         // Split modes drop output 1 when output 2 fires
         if (split && hit[1]) begin
            out_next[0] = 1'b0;
         end
         if (m == pcc_pkg::MODE_AUTO_HIT && hit[FIN]) begin
            cnt_next = start_val;
         end else if (m == pcc_pkg::MODE_AUTO_END && end_ev[FIN]) begin
            cnt_next = cnt_ev ? step : start_val;
         end else if (cnt_ev) begin
            cnt_next = step;
         end
         if (reg_wr) begin
            case (reg_addr)
               pcc_pkg::ADDR_CTRL: begin
                  ctrl_next[pcc_pkg::CTRL_TEST_BIT] = reg_wdata[pcc_pkg::CTRL_TEST_BIT];
                  if (lock_lvl) begin
                     ctrl_next[2:1] = reg_wdata[pcc_pkg::CTRL_DP_LSB +: 2];
                  end
               end
               pcc_pkg::ADDR_PRE1: if (lock_lvl) pre_next[0] = reg_wdata;
               pcc_pkg::ADDR_PRE2: if (lock_lvl) pre_next[1] = reg_wdata;
               pcc_pkg::ADDR_DUR1: if (lock_lvl) dur_next[0] = wval;
               pcc_pkg::ADDR_DUR2: if (lock_lvl) dur_next[1] = wval;
               default: begin
               end
            endcase
         end
         if (man_rst) begin
            cnt_next = start_val;
            out_next = 2'b00;
            tim_next[0] = 16'h0000;
            tim_next[1] = 16'h0000;
         end
      end
      if (DUAL == 0) begin
         out_next[1] = 1'b0;
      end
      pin_next = out_next | {2{ctrl_next[pcc_pkg::CTRL_TEST_BIT] & lock_lvl}};
      if (DUAL == 0) begin
         pin_next[1] = 1'b0;
      end
      store_next = (cnt_next != cnt_reg) ||
                   (pre_next[0] != pre_reg[0]) || (pre_next[1] != pre_reg[1]) ||
                   (dur_next[0] != dur_reg[0]) || (dur_next[1] != dur_reg[1]);
   end

   // ****************************************
   // Register read port
   // ****************************************
   // Unmapped indices read as zero
   always_comb begin
      status = 16'h0000;
      status[pcc_pkg::STS_OUT_LSB +: 2] = out_reg;
      status[pcc_pkg::STS_LOCK_BIT] = ~lock_lvl;
      status[pcc_pkg::STS_DIR_BIT] = dir_lvl;
      status[pcc_pkg::STS_TEST_BIT] = ctrl_reg[pcc_pkg::CTRL_TEST_BIT];
      status[pcc_pkg::STS_MODE_LSB +: 4] = mode_reg;
      rdata_next = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            pcc_pkg::ADDR_CTRL: begin
               rdata_next[pcc_pkg::CTRL_TEST_BIT] = ctrl_reg[pcc_pkg::CTRL_TEST_BIT];
               rdata_next[pcc_pkg::CTRL_DP_LSB +: 2] = ctrl_reg[2:1];
            end
            pcc_pkg::ADDR_PRE1: rdata_next = pre_reg[0];
            pcc_pkg::ADDR_PRE2: rdata_next = pre_reg[1];
            pcc_pkg::ADDR_DUR1: rdata_next = dur_reg[0];
            pcc_pkg::ADDR_DUR2: rdata_next = dur_reg[1];
            pcc_pkg::ADDR_COUNT: rdata_next = cnt_reg;
            pcc_pkg::ADDR_STATUS: rdata_next = status;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // duration resets to 0.1 s
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= pcc_pkg::PCC_ST_RESTORE;
         cnt_reg <= pcc_pkg::COUNT_RST;
         pre_reg[0] <= pcc_pkg::PRE_RST;
         pre_reg[1] <= pcc_pkg::PRE_RST;
         dur_reg[0] <= pcc_pkg::DUR_RST;
         dur_reg[1] <= pcc_pkg::DUR_RST;
         tim_reg[0] <= 16'h0000;
         tim_reg[1] <= 16'h0000;
         out_reg <= 2'b00;
         pin_reg <= 2'b00;
         ctrl_reg <= pcc_pkg::CTRL_RST;
         tick_reg <= '0;
         cprev_reg <= 1'b1;
         rdata_reg <= 16'h0000;
         store_reg <= 1'b0;
         msw1_reg <= 4'h0;
         mode_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
         dur_reg <= dur_next;
         tim_reg <= tim_next;
         out_reg <= out_next;
         pin_reg <= pin_next;
         ctrl_reg <= ctrl_next;
         tick_reg <= tick_next;
         cprev_reg <= cnt_lvl;
         rdata_reg <= rdata_next;
         store_reg <= store_next;
         msw1_reg <= mode_sw;
         mode_reg <= msw1_reg;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // both drivers share one source
   assign ss_out = pin_reg;
   assign relay_out = pin_reg;
   assign reg_rdata = rdata_reg;
   assign nv_store = store_reg;
   assign nv_image_out = {dur_reg[1], dur_reg[0], pre_reg[1], pre_reg[0], cnt_reg};
endmodule

/* inc/pcc_pkg.sv */
// Constants, types and BCD helpers for the preset counter control block
//
// Functional notes
// - zero-start clears, counts up, fires at presets
// - preset-start loads preset, counts down, fires zero
// - dual preset-start loads second preset
// - dual preset-start: out1 at preset1, out2 zero
// - eight single modes, twelve dual modes
// - timed output 0.01 to 99.99 s
// - timed output defaults to 0.1 s
// - remote reset low restarts count and clears outputs
// - lock refuses settings and output self-test
// - direction low down, high up, filtered
// - rear switch gates front reset button
// - self-test keeps counting and output logic running
// - solid-state and relay output per preset
// - operating data restored from non-volatile image
// - manual reset overrides every mode, and every state but restore
// - mode read as binary from switches
package pcc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int DIR_US = 150;
   localparam int DIR_CYC = CLK_HZ / 1_000_000 * DIR_US;
   localparam int RRST_MS = 10;
   localparam int RRST_CYC = CLK_HZ / 1000 * RRST_MS;
   localparam int IN_FILT_US = 10;
   localparam int IN_FILT_CYC = CLK_HZ / 1_000_000 * IN_FILT_US;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PRE1 = 4'h1;
   localparam logic [3:0] ADDR_PRE2 = 4'h2;
   localparam logic [3:0] ADDR_DUR1 = 4'h3;
   localparam logic [3:0] ADDR_DUR2 = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam int CTRL_TEST_BIT = 0;
   localparam int CTRL_DP_LSB = 4;
   localparam int STS_OUT_LSB = 0;
   localparam int STS_LOCK_BIT = 2;
   localparam int STS_DIR_BIT = 3;
   localparam int STS_TEST_BIT = 4;
   localparam int STS_MODE_LSB = 8;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] PRE_RST = 16'h0100;
   localparam logic [15:0] DUR_RST = 16'h0010;
   localparam logic [15:0] DUR_MIN = 16'h0001;
   localparam logic [2:0] CTRL_RST = 3'h0;

   // ****************************************
   // Modes and image layout
   // ****************************************
   localparam int MODE_ACT_BIT = 3;
   localparam logic [2:0] MODE_LATCH = 3'h0;
   localparam logic [2:0] MODE_TIMED = 3'h1;
   localparam logic [2:0] MODE_SPLIT_L = 3'h2;
   localparam logic [2:0] MODE_SPLIT_T = 3'h3;
   localparam logic [2:0] MODE_AUTO_HIT = 3'h4;
   localparam logic [2:0] MODE_AUTO_END = 3'h6;
   localparam int NV_W = 80;
   localparam int NV_CNT_LSB = 0;
   localparam int NV_PRE_LSB = 16;
   localparam int NV_DUR_LSB = 48;

   typedef enum logic [1:0] {
      PCC_ST_RESTORE = 2'b01,
      PCC_ST_RUN = 2'b10
   } pcc_state_e;

   // BCD increment, 9999 wraps to 0000
   function automatic logic [15:0] bcd_inc(input logic [15:0] d);
      logic [15:0] r;
      logic c;
      r = d;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            if (r[i*4 +: 4] == 4'h9) begin
               r[i*4 +: 4] = 4'h0;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // BCD decrement, 0000 wraps to 9999
   function automatic logic [15:0] bcd_dec(input logic [15:0] d);
      logic [15:0] r;
      logic b;
      r = d;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (r[i*4 +: 4] == 4'h0) begin
               r[i*4 +: 4] = 4'h9;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return r;
   endfunction
endpackage

/* sim/pcc_assertions.sv */
// Port-level checker for the preset counter control block
`timescale 1ns/1ps
module pcc_assertions #(
   parameter int RRST_CYC = 4
) (
   input wire logic mclk, // Clock
   input wire logic sys_rst, // Async reset
   input wire logic [3:0] reg_addr, // Register index
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic remote_rst_n, // Remote reset
   input wire logic prog_lock_n, // Program lock
   input wire logic [3:0] mode_sw, // Mode code
   input wire logic [pcc_pkg::NV_W-1:0] nv_image_out, // Live image
   input wire logic nv_store, // Store pulse
   input wire logic [1:0] ss_out, // Solid-state outputs
   input wire logic [1:0] relay_out // Relay outputs
);
   // ****************************************
   // Helper counters
   // ****************************************
   // Margin of 8 covers the two sync flops ahead of each filter
   localparam int RRST_MAX = RRST_CYC + 8;
   localparam int LOCK_MAX = pcc_pkg::IN_FILT_CYC + 8;
   int rrst_reg;
   int rrst_next;
   int lock_reg;
   int lock_next;

   // Run lengths of held-low control inputs, saturating
   always_comb begin
      rrst_next = remote_rst_n ? 0 : ((rrst_reg < RRST_MAX) ? rrst_reg + 1 : rrst_reg);
      lock_next = prog_lock_n ? 0 : ((lock_reg < LOCK_MAX) ? lock_reg + 1 : lock_reg);
   end

   // Register the run lengths
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rrst_reg <= 0;
         lock_reg <= 0;
      end else begin
         rrst_reg <= rrst_next;
         lock_reg <= lock_next;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_hit1;
      $changed(nv_image_out[15:0]) && nv_image_out[15:0] == nv_image_out[31:16]
         && mode_sw == 4'h0 && remote_rst_n;
   endsequence
   sequence s_zero2;
      $changed(nv_image_out[15:0]) && nv_image_out[15:0] == 16'h0000
         && mode_sw == 4'h8 && remote_rst_n;
   endsequence

   a_relay_follow: assert property (relay_out == ss_out)
      else $error("relay outputs differ from solid-state outputs");
   a_count_read: assert property (reg_rd && reg_addr == pcc_pkg::ADDR_COUNT
      |=> reg_rdata == $past(nv_image_out[15:0])) else $error("count read mismatch");
   a_pre_read: assert property (reg_rd && reg_addr == pcc_pkg::ADDR_PRE1
      |=> reg_rdata == $past(nv_image_out[31:16])) else $error("preset read mismatch");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_remote_outs: assert property (rrst_reg == RRST_MAX |-> ss_out == 2'b00)
      else $error("outputs active under remote reset");
   a_remote_zero: assert property (rrst_reg == RRST_MAX && !mode_sw[3]
      |-> nv_image_out[15:0] == 16'h0000) else $error("count not zero under reset");
   a_remote_pre2: assert property (rrst_reg == RRST_MAX && mode_sw[3]
      |-> nv_image_out[15:0] == nv_image_out[47:32]) else $error("count not preset 2");
   a_lock_pre: assert property (lock_reg == LOCK_MAX && reg_wr
      && reg_addr == pcc_pkg::ADDR_PRE1 |=> $stable(nv_image_out[31:16]))
      else $error("preset changed while locked");
   a_store_change: assert property ($changed(nv_image_out) |-> nv_store)
      else $error("no store pulse after image change");
   a_hit_out1: assert property (s_hit1 |-> ##[0:1] ss_out[0])
      else $error("output 1 missed preset 1");
   a_zero_out2: assert property (s_zero2 |-> ##[0:1] ss_out[1])
      else $error("output 2 missed zero");
endmodule

bind pcc_top pcc_assertions #(.RRST_CYC(RRST_CYC)) pcc_assertions_inst (.mclk(mclk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .remote_rst_n(remote_rst_n), .prog_lock_n(prog_lock_n),
   .mode_sw(mode_sw), .nv_image_out(nv_image_out), .nv_store(nv_store),
   .ss_out(ss_out), .relay_out(relay_out));

/* sim/pcc_field.sv */
// Field side model: count sensor, direction switch, remote reset contact
`timescale 1ns/1ps
module pcc_field_model #(
   parameter int LOW_CYC = 1200,
   parameter int HIGH_CYC = 1200
) (
   input wire logic mclk, // Clock
   output logic cnt_in, // Count pin, pulled up
   output logic count_direction_in, // Direction, pulled up
   output logic remote_rst_n // Remote reset, pulled up
);
   // Pins rest at their pull-up level
   initial begin
      cnt_in = 1'b1;
      count_direction_in = 1'b1;
      remote_rst_n = 1'b1;
   end

   // widths also fit a debounced contact
   // Widths stay above the input filter so each pulse is a count
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         cnt_in <= 1'b0;
         repeat (LOW_CYC) @(posedge mclk);
         cnt_in <= 1'b1;
         repeat (HIGH_CYC) @(posedge mclk);
      end
   endtask

   // Direction change, held until past its filter
   task automatic set_dir(input logic d);
      @(posedge mclk);
      count_direction_in <= d;
      repeat (20) @(posedge mclk);
   endtask

   // Remote contact closed then opened for n cycles each
   task automatic hold_reset(input int n);
      @(posedge mclk);
      remote_rst_n <= 1'b0;
      repeat (n) @(posedge mclk);
      remote_rst_n <= 1'b1;
      repeat (n) @(posedge mclk);
   endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the preset counter control block
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic cnt_in;
   logic count_direction_in;
   logic remote_rst_n;
   logic prog_lock_n = 1'b1;
   logic front_rst_btn = 1'b0;
   logic front_rst_en = 1'b0;
   logic [3:0] mode_sw = 4'h0;
   logic [79:0] nv_image_in = '0;
   logic nv_valid_in = 1'b0;
   logic [79:0] nv_image_out;
   logic nv_store;
   logic [1:0] ss_out;
   logic [1:0] relay_out;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [15:0] s;

   always #5 mclk = ~mclk;

   pcc_top #(.DUAL(1), .TICK_CYC(10), .DIR_CYC(4), .RRST_CYC(4)) pcc_top_inst (.mclk(mclk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_in(cnt_in),
      .count_direction_in(count_direction_in), .remote_rst_n(remote_rst_n),
      .prog_lock_n(prog_lock_n), .front_rst_btn(front_rst_btn), .front_rst_en(front_rst_en),
      .mode_sw(mode_sw), .nv_image_in(nv_image_in), .nv_valid_in(nv_valid_in),
      .nv_image_out(nv_image_out), .nv_store(nv_store), .ss_out(ss_out), .relay_out(relay_out));
   pcc_field_model pcc_field_model_inst (.mclk(mclk), .cnt_in(cnt_in),
      .count_direction_in(count_direction_in), .remote_rst_n(remote_rst_n));

   // ****************************************
   // Common tasks
   // ****************************************
   task automatic stop_test();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Hang guard; the full run needs about 35000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(d, e);
   endtask

   // Both output kinds must match
   task automatic outs(input logic [1:0] e);
      chk({14'h0000, ss_out}, {14'h0000, e});
      chk({14'h0000, relay_out}, {14'h0000, e});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_defaults();
      rc(4'h3, 16'h0010);
      rc(4'h4, 16'h0010);
      rc(4'h1, 16'h0100);
      rc(4'h5, 16'h0000);
      rc(4'hF, 16'h0000);
      for (int m = 0; m < 16; m++) begin
         mode_sw <= m[3:0];
         wt(4);
         rd(4'h6, s);
         chk({12'h000, s[11:8]}, m[15:0]);
      end
   endtask

   task automatic t_zero_start();
      mode_sw <= 4'h0;
      wr(4'h1, 16'h0002);
      wr(4'h2, 16'h0003);
      pcc_field_model_inst.hold_reset(20);
      for (int k = 1; k <= 3; k++) begin
         pcc_field_model_inst.pulses(1);
         rc(4'h5, k[15:0]);
         outs(k == 1 ? 2'b00 : (k == 2 ? 2'b01 : 2'b11));
      end
      pcc_field_model_inst.hold_reset(20);
      rc(4'h5, 16'h0000);
      outs(2'b00);
   endtask

   task automatic t_preset_start();
      pcc_field_model_inst.set_dir(1'b0);
      mode_sw <= 4'h8;
      wr(4'h1, 16'h0001);
      wr(4'h2, 16'h0002);
      pcc_field_model_inst.hold_reset(20);
      rc(4'h5, 16'h0002);
      pcc_field_model_inst.pulses(1);
      outs(2'b01);
      pcc_field_model_inst.pulses(1);
      rc(4'h5, 16'h0000);
      outs(2'b11);
      pcc_field_model_inst.set_dir(1'b1);
      pcc_field_model_inst.pulses(1);
      rc(4'h5, 16'h0001);
   endtask

   // Timed output of 300 ticks outlives the pulse, then drops
   task automatic t_timed();
      mode_sw <= 4'h1;
      wr(4'h3, 16'h0300);
      wr(4'h4, 16'h0000);
      rc(4'h4, 16'h0001);
      pcc_field_model_inst.hold_reset(20);
      pcc_field_model_inst.pulses(1);
      chk({15'h0000, ss_out[0]}, 16'h0001);
      wt(1800);
      chk({15'h0000, ss_out[0]}, 16'h0000);
   endtask

   task automatic t_lock();
      prog_lock_n <= 1'b0;
      wt(1100);
      wr(4'h1, 16'h0042);
      rc(4'h1, 16'h0001);
      rd(4'h6, s);
      chk(s & 16'h0004, 16'h0004);
      wr(4'h0, 16'h0001);
      wt(3);
      outs(2'b00);
      prog_lock_n <= 1'b1;
      wt(1100);
      outs(2'b11);
      pcc_field_model_inst.pulses(1);
      rc(4'h5, 16'h0002);
      wr(4'h0, 16'h0000);
      wt(40);
   endtask

   task automatic t_front();
      front_rst_btn <= 1'b1;
      wt(1100);
      front_rst_btn <= 1'b0;
      wt(1100);
      rc(4'h5, 16'h0002);
      front_rst_en <= 1'b1;
      wt(1100);
      front_rst_btn <= 1'b1;
      wt(1100);
      rc(4'h5, 16'h0000);
      front_rst_btn <= 1'b0;
      wt(1100);
   endtask

   // Split latch mode: output 1 drops when output 2 fires
   task automatic t_split();
      mode_sw <= 4'h2;
      pcc_field_model_inst.hold_reset(20);
      pcc_field_model_inst.pulses(2);
      outs(2'b10);
   endtask

   task automatic t_restore();
      nv_image_in <= {16'h0005, 16'h0007, 16'h0023, 16'h0012, 16'h0345};
      nv_valid_in <= 1'b1;
      sys_rst <= 1'b1;
      wt(5);
      sys_rst <= 1'b0;
      wt(4);
      rc(4'h5, 16'h0345);
      rc(4'h1, 16'h0012);
      rc(4'h4, 16'h0005);
      nv_valid_in <= 1'b0;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      wt(5);
      sys_rst <= 1'b0;
      wt(2);
      t_defaults();
      t_zero_start();
      t_preset_start();
      t_timed();
      t_lock();
      t_front();
      t_split();
      t_restore();
      stop_test();
   end
endmodule
